// [verilog/aacr_regs.sv]
// Purpose: host control and status registers of the acquisition card
// Assumes: bus strobes are one-cycle pulses synchronous to clk_sys
// Notes:   read data registered, valid the cycle after rd
`default_nettype none
// Contract
// - result read returns oldest sample, 16 bits low, upper bits zero.
// - each queue write appends channel, enables, gain and input flags unless all QDEPTH slots are loaded.
// - gain codes 00,01,10,11 select gain 1,2,4,8.
// - entry bits 2,1,0 choose unipolar, differential, user common reference.
// - control bit 6 written 1 empties the queue.
// - control bit 5 marks queue valid; only a valid queue is used.
// - control bit 4 written 1 flushes the sample FIFO.
// - control bits 3..0 written 1 clear trigger, scan done, overrun, overspeed.
// - control bit 7 disables scan counter, bit 8 selects DMA.
// - status bit 7 reads 1 while acquisition runs.
// - status bits 6,5,4 read 0 when full, half full, empty.
// - trigger seen and scan done flags latch until written 1.
// - overrun and overspeed flags latch until written 1.
// - digital read gives inputs low, output latch high; write sets outputs.
// - trigger bit 10 written 1 gives exactly one convert pulse.
// - bit 9 enables timing; bit 8 gates triggers until pre count ends.
// - bit 7 allows retrigger; bit 6 selects delay time unit.
// - bit 5 selects external timebase; bit 4 selects falling edge.
// - mode bits 3..1 choose software, post, delay, pre, middle.
// - five interrupt enables bits 12..8, pending 4..0, write 1 clears.
module aacr_regs #(
  parameter int QDEPTH = 512,
  parameter int QAW    = 9
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire aacr_pkg::aacr_bus_t bus,
  output logic      [31:0]        rdata,
  // sample FIFO side
  input  wire logic [15:0]        fifo_head,
  input  wire logic               fifo_empty,
  input  wire logic               fifo_half,
  input  wire logic               fifo_full,
  output logic                    fifo_pop,
  output logic                    fifo_flush,
  // acquisition engine side
  input  wire logic               capture_active,
  input  wire aacr_pkg::aacr_evt_t evt,
  input  wire logic               pre_count_zero,
  input  wire logic               queue_next,
  output aacr_pkg::aacr_entry_t   queue_entry,
  output logic [1:0]              gain_select,
  output logic [3:0]              gain_factor,
  output logic                    queue_ready,
  output logic                    scan_count_disable,
  output logic                    dma_select,
  output aacr_pkg::aacr_trig_t    trig_cfg,
  output logic                    trigger_accept,
  output logic                    convert_pulse,
  // digital port
  input  wire logic [7:0]         din,
  output logic      [7:0]         dout,
  output logic                    irq
);
  typedef struct packed {
    logic [31:0]          rdata;
    logic [7:0]           dout;
    logic [8:0]           ctl;
    aacr_pkg::aacr_trig_t trig;
    logic                 conv;
    logic                 trig_seen;
    logic                 scan_done;
    logic                 overrun;
    logic                 overspeed;
    logic [4:0]           irq_en;
    logic [4:0]           irq_pend;
    logic [QAW-1:0]       q_wr;
    logic [QAW-1:0]       q_rd;
    logic [QAW:0]         q_count;
  } aacr_state_t;

  aacr_state_t s_q;
  aacr_state_t s_d;

  // gain code to factor: 1,2,4,8
  function automatic logic [3:0] gain_of(input logic [1:0] code);
    gain_of = 4'h1 << code;
  endfunction

  // decode one register address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic             wr_ctl;
  logic             wr_que;
  logic             wr_dio;
  logic             wr_trg;
  logic             wr_irq;
  logic             q_accept;
  logic [13:0]      q_rdata;
  logic [4:0]       irq_src;

  // write strobes per register
  assign wr_que = bus.wr && hit(bus.addr, aacr_pkg::OFF_SAMPLE);
  assign wr_ctl = bus.wr && hit(bus.addr, aacr_pkg::OFF_CONTROL);
  assign wr_dio = bus.wr && hit(bus.addr, aacr_pkg::OFF_DIGITAL);
  assign wr_trg = bus.wr && hit(bus.addr, aacr_pkg::OFF_TRIGGER);
  assign wr_irq = bus.wr && hit(bus.addr, aacr_pkg::OFF_IRQ);

  // append refused once every slot is loaded, so a wrapped pointer never overwrites
  assign q_accept = wr_que && s_q.q_count < (QAW+1)'(QDEPTH);

  // interrupt sources ordered timer..end of conversion, bit 4..0
  assign irq_src = {evt.timer, evt.scan_done, evt.half_full, evt.ext_trigger,
                    evt.end_of_conv};

  aacr_queue_mem #(
    .WIDTH (14),
    .DEPTH (QDEPTH),
    .AW    (QAW)
  ) aacr_queue_mem_i (
    .clk_sys (clk_sys),
    .wr_en   (q_accept),
    .wr_addr (s_q.q_wr),
    .wr_data (bus.wdata[13:0]),
    .rd_addr (s_q.q_rd),
    .rd_data (q_rdata)
  );

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.conv = 1'b0;

    // queue pointers: clear wins over append and advance
    if (wr_ctl && bus.wdata[aacr_pkg::CTL_QUEUE_CLEAR]) begin
      s_d.q_wr    = '0;
      s_d.q_rd    = '0;
      s_d.q_count = '0;
    end else begin
      if (q_accept) begin
        s_d.q_wr    = s_q.q_wr + 1'b1;
        s_d.q_count = s_q.q_count + 1'b1;
      end
      // wrap through the loaded entries only when the queue is valid
      if (queue_next && s_q.ctl[aacr_pkg::CTL_QUEUE_VALID] && s_q.q_count != '0) begin
        if ({1'b0, s_q.q_rd} == s_q.q_count - 1'b1) begin
          s_d.q_rd = '0;
        end else begin
          s_d.q_rd = s_q.q_rd + 1'b1;
        end
      end
    end

    // control word: level bits kept, strobe bits used once
    if (wr_ctl) begin
      s_d.ctl = bus.wdata[8:0];
    end

    // sticky status flags, set wins over clear
    s_d.trig_seen = evt.ext_trigger | (s_q.trig_seen &
      ~(wr_ctl & bus.wdata[aacr_pkg::CTL_TRIG_CLR]));
    s_d.scan_done = evt.scan_done | (s_q.scan_done &
      ~(wr_ctl & bus.wdata[aacr_pkg::CTL_SCANDONE_CLR]));
    s_d.overrun = evt.overrun | (s_q.overrun &
      ~(wr_ctl & bus.wdata[aacr_pkg::CTL_OVERRUN_CLR]));
    s_d.overspeed = evt.overspeed | (s_q.overspeed &
      ~(wr_ctl & bus.wdata[aacr_pkg::CTL_OVERSPEED_CLR]));

    // digital outputs
    if (wr_dio) begin
      s_d.dout = bus.wdata[7:0];
    end

    // trigger configuration and software convert
    if (wr_trg) begin
      s_d.trig.timing_run        = bus.wdata[aacr_pkg::TRG_TIMING_RUN];
      s_d.trig.pre_gate          = bus.wdata[aacr_pkg::TRG_PRE_GATE];
      s_d.trig.retrigger         = bus.wdata[aacr_pkg::TRG_RETRIG];
      s_d.trig.delay_unit_select = bus.wdata[aacr_pkg::TRG_DELAY_UNIT];
      s_d.trig.ext_timebase      = bus.wdata[aacr_pkg::TRG_EXT_BASE];
      s_d.trig.edge_polarity     = bus.wdata[aacr_pkg::TRG_POLARITY];
      s_d.trig.mode = aacr_pkg::aacr_mode_t'(bus.wdata[aacr_pkg::TRG_MODE_LSB +: 3]);
      s_d.conv = bus.wdata[aacr_pkg::TRG_SOFT_CONV];
    end

    // interrupt enables and pending flags, set wins over clear
    if (wr_irq) begin
      s_d.irq_en = bus.wdata[aacr_pkg::IRQ_EN_LSB +: aacr_pkg::IRQ_COUNT];
    end
    s_d.irq_pend = irq_src | (s_q.irq_pend &
      ~({5{wr_irq}} & bus.wdata[aacr_pkg::IRQ_CLR_LSB +: aacr_pkg::IRQ_COUNT]));

    // registered read data, zero for unmapped offsets
    s_d.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        aacr_pkg::OFF_SAMPLE:  s_d.rdata = {16'h0000, fifo_head};
        aacr_pkg::OFF_CONTROL: s_d.rdata = {24'h000000, capture_active,
          ~fifo_full, ~fifo_half, ~fifo_empty,
          s_q.trig_seen, s_q.scan_done, s_q.overrun, s_q.overspeed};
        aacr_pkg::OFF_DIGITAL: s_d.rdata = {16'h0000, s_q.dout, din};
        aacr_pkg::OFF_IRQ:     s_d.rdata = {27'h0000000, s_q.irq_pend};
        default:               s_d.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{rdata: '0, dout: aacr_pkg::DOUT_RESET, ctl: aacr_pkg::CTL_RESET,
               trig: aacr_pkg::aacr_trig_t'(aacr_pkg::TRG_RESET[9:0]), default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // bus side effects
  assign rdata      = s_q.rdata;
  assign fifo_pop   = bus.rd && hit(bus.addr, aacr_pkg::OFF_SAMPLE) && !fifo_empty;
  assign fifo_flush = wr_ctl && bus.wdata[aacr_pkg::CTL_FIFO_FLUSH];

  // decoded queue entry towards the front end
  assign queue_entry = aacr_pkg::aacr_entry_t'(q_rdata);
  assign gain_select = q_rdata[aacr_pkg::QE_GAIN_LSB +: 2];
  assign gain_factor = gain_of(q_rdata[aacr_pkg::QE_GAIN_LSB +: 2]);
  assign queue_ready = s_q.ctl[aacr_pkg::CTL_QUEUE_VALID] && s_q.q_count != '0;

  // level controls and the one-cycle convert pulse
  assign scan_count_disable = s_q.ctl[aacr_pkg::CTL_SCAN_DISABLE];
  assign dma_select         = s_q.ctl[aacr_pkg::CTL_DMA_SELECT];
  assign trig_cfg           = s_q.trig;
  assign trigger_accept     = s_q.trig.timing_run &&
                              (!s_q.trig.pre_gate || pre_count_zero);
  assign convert_pulse      = s_q.conv;
  assign dout               = s_q.dout;
  assign irq                = |(s_q.irq_pend & s_q.irq_en);
endmodule
`default_nettype wire

// [verilog/aacr_pkg.sv]
// Purpose: shared constants and carriers for the acquisition control registers
// Assumes: 32-bit register words, byte offsets as printed
// Notes:   offsets are byte addresses; reserved bits read zero
`default_nettype none
package aacr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SAMPLE   = 8'h24;
  localparam logic [7:0] OFF_CONTROL  = 8'h28;
  localparam logic [7:0] OFF_DIGITAL  = 8'h30;
  localparam logic [7:0] OFF_TRIGGER  = 8'h34;
  localparam logic [7:0] OFF_IRQ      = 8'h38;
  // control write bits
  localparam int CTL_OVERSPEED_CLR = 0;
  localparam int CTL_OVERRUN_CLR   = 1;
  localparam int CTL_SCANDONE_CLR  = 2;
  localparam int CTL_TRIG_CLR      = 3;
  localparam int CTL_FIFO_FLUSH    = 4;
  localparam int CTL_QUEUE_VALID   = 5;
  localparam int CTL_QUEUE_CLEAR   = 6;
  localparam int CTL_SCAN_DISABLE  = 7;
  localparam int CTL_DMA_SELECT    = 8;
  // status read bits
  localparam int STA_CAPTURE  = 7;
  localparam int STA_FULL_N   = 6;
  localparam int STA_HALF_N   = 5;
  localparam int STA_EMPTY_N  = 4;
  // queue entry fields
  localparam int QE_CFG_LSB   = 0;
  localparam int QE_EN_LSB    = 4;
  localparam int QE_CH_LSB    = 8;
  localparam int QE_GAIN_LSB  = 12;
  // trigger configuration bits
  localparam int TRG_MODE_LSB   = 1;
  localparam int TRG_POLARITY   = 4;
  localparam int TRG_EXT_BASE   = 5;
  localparam int TRG_DELAY_UNIT = 6;
  localparam int TRG_RETRIG     = 7;
  localparam int TRG_PRE_GATE   = 8;
  localparam int TRG_TIMING_RUN = 9;
  localparam int TRG_SOFT_CONV  = 10;
  // interrupt fields
  localparam int IRQ_CLR_LSB  = 0;
  localparam int IRQ_EN_LSB   = 8;
  localparam int IRQ_COUNT    = 5;
  // digital port fields
  localparam int DIO_OUT_LSB  = 8;
  // reset values
  localparam logic [7:0]  DOUT_RESET = 8'h00;
  localparam logic [10:0] TRG_RESET  = 11'h000;
  localparam logic [8:0]  CTL_RESET  = 9'h000;

  typedef enum logic [2:0] {
    AACR_SOFTWARE = 3'h0,
    AACR_POST     = 3'h1,
    AACR_DELAY    = 3'h2,
    AACR_PRE      = 3'h3,
    AACR_MIDDLE   = 3'h4
  } aacr_mode_t;

  // one decoded queue entry
  typedef struct packed {
    logic [1:0] gain_code;
    logic [3:0] channel;
    logic [3:0] mux_enable;
    logic       upper_bank_select;
    logic       positive_only_range;
    logic       two_wire_input;
    logic       user_common_ref;
  } aacr_entry_t;

  // trigger configuration fields
  typedef struct packed {
    logic       timing_run;
    logic       pre_gate;
    logic       retrigger;
    logic       delay_unit_select;
    logic       ext_timebase;
    logic       edge_polarity;
    aacr_mode_t mode;
  } aacr_trig_t;

  // host bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } aacr_bus_t;

  // acquisition engine events, one-cycle pulses
  typedef struct packed {
    logic timer;
    logic scan_done;
    logic half_full;
    logic ext_trigger;
    logic end_of_conv;
    logic overrun;
    logic overspeed;
  } aacr_evt_t;
endpackage
`default_nettype wire

// [verilog/aacr_queue_mem.sv]
// Purpose: channel/gain queue storage with registered read data
// Assumes: one write and one read port, same clock
// Notes:   contents undefined until loaded; pointers live in the caller
`default_nettype none
module aacr_queue_mem #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic             clk_sys,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write port and registered read port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [tb/aacr_regs_chk.sv]
// Purpose: port assertions for aacr_regs
// Assumes: one clock, async active-low reset
// Notes:   bound to every aacr_regs instance
`default_nettype none
module aacr_regs_chk (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire aacr_pkg::aacr_bus_t bus,
  input wire logic [31:0]         rdata,
  input wire logic [15:0]         fifo_head,
  input wire logic                fifo_empty,
  input wire logic                fifo_pop,
  input wire logic                fifo_flush,
  input wire aacr_pkg::aacr_evt_t evt,
  input wire logic [3:0]          gain_factor,
  input wire logic [1:0]          gain_select,
  input wire logic                convert_pulse,
  input wire logic [7:0]          din,
  input wire logic [7:0]          dout,
  input wire logic                irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // host requests at one offset
  sequence rd_at(a); bus.rd && bus.addr == a; endsequence
  sequence wr_at(a); bus.wr && bus.addr == a; endsequence
  sequence conv_req; wr_at(8'h34) ##0 bus.wdata[10]; endsequence
  chk_pop_read: assert property (
    fifo_pop == (bus.rd && bus.addr == 8'h24 && !fifo_empty)) else $error("pop");
  chk_flush_write: assert property (
    fifo_flush == (bus.wr && bus.addr == 8'h28 && bus.wdata[4])) else $error("flush");
  chk_result_word: assert property (
    rd_at(8'h24) |=> rdata == {16'h0000, $past(fifo_head)}) else $error("result");
  chk_dio_word: assert property (
    rd_at(8'h30) |=> rdata == {16'h0000, $past(dout), $past(din)}) else $error("dio");
  chk_dout_write: assert property (
    wr_at(8'h30) |=> dout == $past(bus.wdata[7:0])) else $error("dout");
  chk_conv_pulse: assert property (
    conv_req |=> convert_pulse) else $error("conv");
  chk_conv_quiet: assert property (
    !(bus.wr && bus.addr == 8'h34 && bus.wdata[10]) |=> !convert_pulse) else $error("conv");
  chk_gain_map: assert property (
    gain_factor == (gain_select == 2'h0 ? 4'h1 : gain_select == 2'h1 ? 4'h2 :
                    gain_select == 2'h2 ? 4'h4 : 4'h8)) else $error("gain");
  chk_irq_clear: assert property (
    wr_at(8'h38) ##0 (bus.wdata[4:0] == 5'h1F && evt[6:2] == 5'h00) |=> !irq)
    else $error("irq");
endmodule
bind aacr_regs aacr_regs_chk aacr_regs_chk_i (
  .clk_sys, .rst_b, .bus, .rdata, .fifo_head, .fifo_empty, .fifo_pop, .fifo_flush,
  .evt, .gain_factor, .gain_select, .convert_pulse, .din, .dout, .irq
);
`default_nettype wire

// [tb/aacr_regs_test.sv]
// Purpose: self-checking bench for aacr_regs
// Assumes: 200 MHz clk_sys, rst_b low for 16 cycles
// Notes:   drive on rising edge, check on falling edge
`default_nettype none
module aacr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys = 1'b0;
  logic                  rst_b = 1'b0;
  aacr_pkg::aacr_bus_t   bus = '0;
  aacr_pkg::aacr_evt_t   evt = '0;
  logic [15:0]           fifo_head = 16'h0000;
  logic [7:0]            din = 8'h00;
  logic                  fifo_empty = 1'b1, fifo_half = 1'b0, fifo_full = 1'b0;
  logic                  capture_active = 1'b0, pre_count_zero = 1'b0, queue_next = 1'b0;
  logic [31:0]           rdata, rd_val;
  logic [7:0]            dout;
  logic [3:0]            gain_factor;
  logic [1:0]            gain_select;
  logic                  fifo_pop, fifo_flush, queue_ready, scan_count_disable, dma_select;
  logic                  trigger_accept, convert_pulse, irq, conv_seen;
  aacr_pkg::aacr_entry_t queue_entry;
  aacr_pkg::aacr_trig_t  trig_cfg;
  int                    n_fail = 0, checked = 0;
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  aacr_regs aacr_regs_i (
    .clk_sys, .rst_b, .bus, .rdata, .fifo_head, .fifo_empty, .fifo_half, .fifo_full,
    .fifo_pop, .fifo_flush, .capture_active, .evt, .pre_count_zero, .queue_next,
    .queue_entry, .gain_select, .gain_factor, .queue_ready, .scan_count_disable,
    .dma_select, .trig_cfg, .trigger_accept, .convert_pulse, .din, .dout, .irq
  );
  // compare and count
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  // one request for one edge, answer taken at the falling edge after
  task automatic xfer(input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk_sys);
    bus <= '0;
    @(negedge clk_sys);
    rd_val = rdata;
    conv_seen = convert_pulse;
  endtask
  // one-cycle engine event pulse
  task automatic pulse(input logic [6:0] e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
    @(negedge clk_sys);
  endtask
  task automatic t_ports();
    @(negedge clk_sys);
    cmp("dout rst", 32'h0, dout);
    @(posedge clk_sys);
    din <= 8'hA5;
    fifo_head <= 16'h8001;
    fifo_empty <= 1'b0;
    xfer(1'b0, 8'h30, 32'hFFFF_FF3C);
    cmp("dout", 32'h3C, dout);
    xfer(1'b1, 8'h30, 32'h0);
    cmp("dio", 32'h0000_3CA5, rd_val);
    xfer(1'b1, 8'h24, 32'h0);
    cmp("result", 32'h0000_8001, rd_val);
    $display("ports done");
  endtask
  task automatic t_status();
    @(posedge clk_sys);
    capture_active <= 1'b1;
    fifo_full <= 1'b1;
    fifo_half <= 1'b1;
    pulse(7'h2B);
    xfer(1'b0, 8'h28, 32'h0);
    xfer(1'b1, 8'h28, 32'h0);
    cmp("status", 32'h9F, rd_val);
    xfer(1'b0, 8'h28, 32'h0199);
    cmp("dma", 32'h1, dma_select);
    cmp("sc off", 32'h1, scan_count_disable);
    xfer(1'b1, 8'h28, 32'h0);
    cmp("clr a", 32'h96, rd_val);
    xfer(1'b0, 8'h28, 32'h06);
    @(posedge clk_sys);
    capture_active <= 1'b0;
    fifo_full <= 1'b0;
    fifo_half <= 1'b0;
    fifo_empty <= 1'b1;
    xfer(1'b1, 8'h28, 32'h0);
    cmp("clr b", 32'h60, rd_val);
    $display("status done");
  endtask
  task automatic t_queue();
    xfer(1'b0, 8'h28, 32'h40);
    for (int g = 0; g < 4; g++) xfer(1'b0, 8'h24, {18'h0, 2'(g), 8'hA5, 4'(g * 5)});
    cmp("not valid", 32'h0, queue_ready);
    xfer(1'b0, 8'h28, 32'h20);
    repeat (3) @(negedge clk_sys);
    cmp("valid", 32'h1, queue_ready);
    for (int g = 0; g < 4; g++) begin
      cmp("entry", {18'h0, 2'(g), 8'hA5, 4'(g * 5)}, queue_entry);
      cmp("gain", 32'h1 << g, gain_factor);
      @(posedge clk_sys);
      queue_next <= 1'b1;
      @(posedge clk_sys);
      queue_next <= 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    xfer(1'b0, 8'h28, 32'h60);
    cmp("emptied", 32'h0, queue_ready);
    $display("queue done");
  endtask
  task automatic t_trig();
    for (int m = 0; m < 5; m++) begin
      xfer(1'b0, 8'h34, {24'h0, m[0] ? 4'hF : 4'h0, 3'(m), 1'b0});
      cmp("trig", {25'h0, m[0] ? 4'hF : 4'h0, 3'(m)}, trig_cfg);
    end
    xfer(1'b0, 8'h34, 32'h0300);
    cmp("gated", 32'h0, trigger_accept);
    @(posedge clk_sys);
    pre_count_zero <= 1'b1;
    @(negedge clk_sys);
    cmp("open", 32'h1, trigger_accept);
    xfer(1'b0, 8'h34, 32'h0400);
    cmp("conv", 32'h1, conv_seen);
    @(negedge clk_sys);
    cmp("conv once", 32'h0, convert_pulse);
    cmp("no timing", 32'h0, trigger_accept);
    $display("trigger done");
  endtask
  task automatic t_irq();
    xfer(1'b0, 8'h38, 32'h1F00);
    pulse(7'h7C);
    cmp("irq on", 32'h1, irq);
    xfer(1'b1, 8'h38, 32'h0);
    cmp("pending", 32'h1F, rd_val);
    xfer(1'b0, 8'h38, 32'h1F0F);
    xfer(1'b1, 8'h38, 32'h0);
    cmp("left", 32'h10, rd_val);
    cmp("irq held", 32'h1, irq);
    xfer(1'b0, 8'h38, 32'h0F00);
    cmp("masked", 32'h0, irq);
    xfer(1'b0, 8'h38, 32'h001F);
    xfer(1'b1, 8'h38, 32'h0);
    cmp("cleared", 32'h0, rd_val);
    xfer(1'b1, 8'h2C, 32'h0);
    cmp("unmapped", 32'h0, rd_val);
    $display("irq done");
  endtask
  // reset in mid-run clears latches and sticky flags
  task automatic t_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    cmp("dout again", 32'h0, dout);
    cmp("irq again", 32'h0, irq);
    cmp("trig again", 32'h0, trig_cfg);
    xfer(1'b1, 8'h28, 32'h0);
    cmp("flags again", 32'h60, rd_val);
    $display("reset done");
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_ports();
    t_status();
    t_queue();
    t_trig();
    t_irq();
    t_reset();
    finish_test();
  end
  // watchdog, about 35 times the expected run
  initial begin
    #20000;
    n_fail++;
    $display("[FAIL] watchdog exp done got hang");
    finish_test();
  end
endmodule
`default_nettype wire
